// ==== logic/pkl_dial_step.sv ====
// Saturating frequency step for one dial click
`timescale 1ns/10ps
module pkl_dial_step (
  // Current value and step choice
  input wire logic [15:0] i_value,
  input wire logic [2:0] i_step_sel,
  input wire logic i_up,
  input wire logic i_dn,
  // Next value
  output logic [15:0] o_next
);

  logic [15:0] step;
  logic [16:0] sum;

  always_comb begin
    step = pkl_pkg::step_of(i_step_sel);
    sum = {1'b0, i_value} + {1'b0, step};
    o_next = i_value;
    if (i_up && !i_dn) begin
      o_next = (sum > {1'b0, pkl_pkg::FREQ_MAX}) ? pkl_pkg::FREQ_MAX : sum[15:0];
    end else if (i_dn && !i_up) begin
      o_next = (i_value < step) ? 16'h0000 : i_value - step;
    end
  end

endmodule : pkl_dial_step

// ==== logic/pkl_hold_det.sv ====
// Mode key long-hold and short-press detector
`timescale 1ns/10ps
module pkl_hold_det #(
  parameter int unsigned HOLD_CYC = pkl_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Key level
  input wire logic i_key,
  // Events
  output logic o_long,
  output logic o_short
);

  localparam logic [pkl_pkg::CNT_W-1:0] HOLD_LAST = pkl_pkg::CNT_W'(HOLD_CYC - 1);

  logic [pkl_pkg::CNT_W-1:0] cnt_q;
  logic fired_q;
  logic key_q;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      key_q <= 1'b0;
    end else begin
      key_q <= i_key;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
      o_long <= 1'b0;
    end else begin
      o_long <= 1'b0;
      if (!i_key) begin
        cnt_q <= '0;
        fired_q <= 1'b0;
      end else if (!fired_q) begin
        if (cnt_q == HOLD_LAST) begin
          o_long <= 1'b1;
          fired_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end

  // Release before the hold threshold is a normal key action
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_short <= 1'b0;
    end else begin
      o_short <= key_q && !i_key && !fired_q && !o_long;
    end
  end

  a_short_not_long: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    fired_q |=> !o_short)
    else $error("short press reported after a long hold");

endmodule : pkl_hold_det

// ==== logic/pkl_panel.sv ====
// Operator panel input logic: key lock, dial step and run direction
`timescale 1ns/10ps
module pkl_panel #(
  parameter int unsigned HOLD_CYC = pkl_pkg::HOLD_CYCLES,
  parameter int unsigned MSG_CYC = pkl_pkg::MSG_CYCLES
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rd_data,
  // Panel keys and dial
  input wire logic i_mode_key,
  input wire logic i_set_key,
  input wire logic i_run_key,
  input wire logic i_stop_key,
  input wire logic i_mode_switch_key,
  input wire logic i_dial_up,
  input wire logic i_dial_dn,
  // Drive context
  input wire logic i_edit_other,
  input wire logic i_op_mode_initial,
  input wire logic i_panel_stop_event,
  input wire logic [15:0] i_monitor_value,
  // Commands to the drive
  output logic o_run_fwd,
  output logic o_run_rev,
  output logic o_stop_cmd,
  output logic o_mode_action,
  output logic o_param_up,
  output logic o_param_dn,
  output logic [15:0] o_freq_cmd,
  output logic o_freq_store,
  // Display and state
  output logic o_locked,
  output logic o_panel_stop_warning,
  output logic o_disp_lock_msg,
  output logic o_disp_freq_edit,
  output logic [15:0] o_disp_value,
  output logic o_speed_units
);

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic [7:0] key_lock_select_q;
  logic [2:0] dial_step_select_q;
  logic run_direction_select_q;
  logic speed_unit_select_q;
  logic wr_cfg;
  logic [7:0] wr_lock;
  logic [2:0] wr_step;

  assign wr_cfg = i_wr && (i_addr == pkl_pkg::CFG_OFS);
  assign wr_lock = i_wr_data[pkl_pkg::LOCK_SEL_LSB +: 8];
  assign wr_step = i_wr_data[pkl_pkg::STEP_SEL_LSB +: 3];

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      key_lock_select_q <= pkl_pkg::LOCK_SEL_RESET;
      dial_step_select_q <= pkl_pkg::STEP_SEL_RESET;
      run_direction_select_q <= pkl_pkg::RUN_DIR_RESET;
      speed_unit_select_q <= pkl_pkg::SPEED_UNIT_RESET;
    end else if (wr_cfg) begin
      // Out-of-range selections keep the old value
      if (wr_lock == pkl_pkg::LOCK_SEL_OFF || pkl_pkg::auto_set(wr_lock) ||
          pkl_pkg::lock_capable(wr_lock)) begin
        key_lock_select_q <= wr_lock;
      end
      if (wr_step <= pkl_pkg::STEP_SEL_MAX) begin
        dial_step_select_q <= wr_step;
      end
      run_direction_select_q <= i_wr_data[pkl_pkg::RUN_DIR_BIT];
      speed_unit_select_q <= i_wr_data[pkl_pkg::SPEED_UNIT_BIT];
    end
  end

  // ----------------------------------------
  // Mode key hold and lock state
  // ----------------------------------------
  logic hold_long;
  logic hold_short;
  logic locked_q;
  logic capable;

  pkl_hold_det #(
    .HOLD_CYC(HOLD_CYC)
  ) u_hold (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_key(i_mode_key),
    .o_long(hold_long),
    .o_short(hold_short)
  );

  assign capable = pkl_pkg::lock_capable(key_lock_select_q);

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      locked_q <= 1'b0;
    end else if (!capable) begin
      locked_q <= 1'b0;
    end else if (hold_long) begin
      locked_q <= !locked_q;
    end
  end

  // ----------------------------------------
  // Display selection and message timer
  // ----------------------------------------
  localparam logic [pkl_pkg::CNT_W-1:0] MSG_LAST = pkl_pkg::CNT_W'(MSG_CYC - 1);
  pkl_pkg::pkl_disp_t disp_q;
  logic [pkl_pkg::CNT_W-1:0] msg_cnt_q;
  logic attempt;
  logic dial_any;
  logic unlocked_freq_dial;

  assign dial_any = i_dial_up || i_dial_dn;
  assign attempt = locked_q && (dial_any || i_set_key || i_run_key || i_mode_switch_key ||
                                hold_short);
  assign unlocked_freq_dial = !locked_q && dial_any && !i_edit_other;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      msg_cnt_q <= '0;
    end else if (attempt || (hold_long && capable)) begin
      msg_cnt_q <= '0;
    end else if (disp_q == pkl_pkg::DISP_LOCK_MSG && msg_cnt_q != MSG_LAST) begin
      msg_cnt_q <= msg_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      disp_q <= pkl_pkg::DISP_MONITOR;
    end else if (hold_long && capable) begin
      disp_q <= locked_q ? pkl_pkg::DISP_MONITOR : pkl_pkg::DISP_LOCK_MSG;
    end else if (attempt) begin
      disp_q <= pkl_pkg::DISP_LOCK_MSG;
    end else begin
      unique case (disp_q)
        pkl_pkg::DISP_LOCK_MSG: begin
          if (msg_cnt_q == MSG_LAST || !locked_q) begin
            disp_q <= pkl_pkg::DISP_MONITOR;
          end
        end
        pkl_pkg::DISP_FREQ_EDIT: begin
          if (i_set_key || pkl_pkg::auto_set(key_lock_select_q)) begin
            disp_q <= unlocked_freq_dial ? pkl_pkg::DISP_FREQ_EDIT : pkl_pkg::DISP_MONITOR;
          end
        end
        pkl_pkg::DISP_MONITOR: begin
          if (unlocked_freq_dial && !pkl_pkg::auto_set(key_lock_select_q)) begin
            disp_q <= pkl_pkg::DISP_FREQ_EDIT;
          end
        end
        default: disp_q <= pkl_pkg::DISP_MONITOR;
      endcase
    end
  end

  // ----------------------------------------
  // Frequency setting by dial
  // ----------------------------------------
  logic [15:0] pend_q;
  logic [15:0] pend_next;
  logic auto_mode;

  assign auto_mode = pkl_pkg::auto_set(key_lock_select_q);

  pkl_dial_step u_step (
    .i_value(pend_q),
    .i_step_sel(dial_step_select_q),
    .i_up(i_dial_up),
    .i_dn(i_dial_dn),
    .o_next(pend_next)
  );

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pend_q <= pkl_pkg::FREQ_RESET;
    end else if (unlocked_freq_dial) begin
      pend_q <= pend_next;
    end else if (disp_q == pkl_pkg::DISP_MONITOR && !auto_mode) begin
      pend_q <= o_freq_cmd;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_freq_cmd <= pkl_pkg::FREQ_RESET;
      o_freq_store <= 1'b0;
    end else begin
      o_freq_store <= 1'b0;
      if (auto_mode && unlocked_freq_dial) begin
        o_freq_cmd <= pend_next;
        o_freq_store <= 1'b1;
      end else if (!auto_mode && !locked_q && i_set_key &&
                   disp_q == pkl_pkg::DISP_FREQ_EDIT) begin
        o_freq_cmd <= pend_q;
        o_freq_store <= 1'b1;
      end
    end
  end

  // Other frequency settings always move by the default step via the parameter editor
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_param_up <= 1'b0;
      o_param_dn <= 1'b0;
    end else begin
      o_param_up <= !locked_q && i_edit_other && i_dial_up && !i_dial_dn;
      o_param_dn <= !locked_q && i_edit_other && i_dial_dn && !i_dial_up;
    end
  end

  // ----------------------------------------
  // Run, stop and mode commands
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_run_fwd <= 1'b0;
      o_run_rev <= 1'b0;
      o_stop_cmd <= 1'b0;
      o_mode_action <= 1'b0;
    end else begin
      o_run_fwd <= i_run_key && !locked_q && !run_direction_select_q;
      o_run_rev <= i_run_key && !locked_q && run_direction_select_q;
      o_stop_cmd <= i_stop_key;
      o_mode_action <= hold_short && !locked_q;
    end
  end

  // ----------------------------------------
  // Panel-stop warning
  // ----------------------------------------
  logic warn_q;
  logic [1:0] ms_cnt_q;
  logic clear_ok;

  assign clear_ok = !locked_q && i_op_mode_initial;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ms_cnt_q <= '0;
    end else if (!warn_q || !clear_ok) begin
      ms_cnt_q <= '0;
    end else if (i_mode_switch_key) begin
      ms_cnt_q <= (ms_cnt_q == pkl_pkg::MS_PRESSES - 2'h1) ? 2'h0 : ms_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      warn_q <= 1'b0;
    end else if (i_panel_stop_event) begin
      warn_q <= 1'b1;
    end else if (clear_ok && i_mode_switch_key &&
                 ms_cnt_q == pkl_pkg::MS_PRESSES - 2'h1) begin
      warn_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs and register reads
  // ----------------------------------------
  assign o_locked = locked_q;
  assign o_panel_stop_warning = warn_q;
  assign o_disp_lock_msg = (disp_q == pkl_pkg::DISP_LOCK_MSG);
  assign o_disp_freq_edit = (disp_q == pkl_pkg::DISP_FREQ_EDIT);
  assign o_speed_units = speed_unit_select_q;

  // Display shows monitor or frequency, never the step
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_disp_value <= '0;
    end else begin
      o_disp_value <= (disp_q == pkl_pkg::DISP_FREQ_EDIT) ? pend_q : i_monitor_value;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= '0;
      if (i_rd) begin
        unique case (i_addr)
          pkl_pkg::CFG_OFS: begin
            o_rd_data[pkl_pkg::LOCK_SEL_LSB +: 8] <= key_lock_select_q;
            o_rd_data[pkl_pkg::STEP_SEL_LSB +: 3] <= dial_step_select_q;
            o_rd_data[pkl_pkg::RUN_DIR_BIT] <= run_direction_select_q;
            o_rd_data[pkl_pkg::SPEED_UNIT_BIT] <= speed_unit_select_q;
          end
          pkl_pkg::STATUS_OFS: begin
            o_rd_data[pkl_pkg::ST_LOCKED_BIT] <= locked_q;
            o_rd_data[pkl_pkg::ST_WARN_BIT] <= warn_q;
            o_rd_data[pkl_pkg::ST_DISP_LSB +: 2] <= disp_q;
          end
          pkl_pkg::FREQ_OFS: begin
            o_rd_data[15:0] <= o_freq_cmd;
          end
          default: o_rd_data <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_lock_toggle: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    hold_long && capable && !wr_cfg |=> locked_q != $past(locked_q))
    else $error("lock did not toggle on long hold");

  a_lock_msg_on: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    hold_long && capable && !locked_q && !wr_cfg |=> locked_q ##0 o_disp_lock_msg)
    else $error("lock message missing after locking");

  a_attempt_msg: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    attempt && !hold_long |=> o_disp_lock_msg && msg_cnt_q == '0)
    else $error("attempt while locked did not show lock message");

  a_lock_refused: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !capable && !wr_cfg |=> !locked_q)
    else $error("lock engaged without lock-capable selection");

  a_stop_live: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_stop_key |=> o_stop_cmd)
    else $error("stop key not honoured");

  a_run_dir: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    i_run_key && !locked_q |=> (o_run_rev == $past(run_direction_select_q)) &&
                               (o_run_fwd == !$past(run_direction_select_q)))
    else $error("run direction wrong");

  a_locked_no_run: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    locked_q |=> !o_run_fwd && !o_run_rev && !o_param_up && !o_param_dn)
    else $error("command issued while locked");

  a_warn_kept: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    locked_q && warn_q |=> warn_q)
    else $error("warning cleared while locked");

  a_dial_step: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    unlocked_freq_dial && i_dial_up && !i_dial_dn &&
    pend_q <= pkl_pkg::FREQ_MAX - pkl_pkg::step_of(dial_step_select_q)
    |=> pend_q == $past(pend_q) + pkl_pkg::step_of($past(dial_step_select_q)))
    else $error("dial step size wrong");

  a_auto_store: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    auto_mode && unlocked_freq_dial |=> o_freq_store && o_freq_cmd == pend_q)
    else $error("automatic frequency setting did not store");

  a_warn_clear: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    clear_ok && warn_q && !i_panel_stop_event && i_mode_switch_key && ms_cnt_q == 2'h2
    |=> !warn_q)
    else $error("third mode switch press did not clear warning");

  c_lock: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !locked_q ##1 locked_q);
  c_unlock: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    locked_q ##1 !locked_q);
  c_msg_return: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_disp_lock_msg ##1 !o_disp_lock_msg && locked_q);
  c_warn_clear: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    warn_q ##1 !warn_q);

endmodule : pkl_panel

// ==== pkg/pkl_pkg.sv ====
// Package: constants, field layout and types of the panel key lock and dial step block
package pkl_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned HOLD_TIME_MS = 2000;
  localparam int unsigned MSG_TIME_MS = 2000;
  localparam int unsigned HOLD_CYCLES = HOLD_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned MSG_CYCLES = MSG_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W = 25;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] FREQ_OFS = 8'h08;

  // CFG fields
  localparam int unsigned LOCK_SEL_LSB = 0;
  localparam int unsigned STEP_SEL_LSB = 8;
  localparam int unsigned RUN_DIR_BIT = 12;
  localparam int unsigned SPEED_UNIT_BIT = 13;

  // STATUS fields
  localparam int unsigned ST_LOCKED_BIT = 0;
  localparam int unsigned ST_WARN_BIT = 1;
  localparam int unsigned ST_DISP_LSB = 2;

  // Key lock selection values
  localparam logic [7:0] LOCK_SEL_OFF = 8'h00;
  localparam logic [7:0] LOCK_SEL_AUTO = 8'h01;
  localparam logic [7:0] LOCK_SEL_LOCK = 8'h0A;
  localparam logic [7:0] LOCK_SEL_LOCK_AUTO = 8'h0B;

  // Dial step selection codes: 0 and 1 both 0.01 Hz, then 0.10, 1.00, 10.00 Hz
  localparam logic [2:0] STEP_SEL_OFF = 3'h0;
  localparam logic [2:0] STEP_SEL_MAX = 3'h4;
  localparam logic [15:0] STEP_DEFAULT = 16'h0001;

  // Frequency in 0.01 Hz units
  localparam logic [15:0] FREQ_MAX = 16'h2EE0;
  localparam logic [15:0] FREQ_RESET = 16'h0000;

  // Reset values and mode switch press count
  localparam logic [7:0] LOCK_SEL_RESET = LOCK_SEL_OFF;
  localparam logic [2:0] STEP_SEL_RESET = STEP_SEL_OFF;
  localparam logic RUN_DIR_RESET = 1'b0;
  localparam logic SPEED_UNIT_RESET = 1'b0;
  localparam logic [1:0] MS_PRESSES = 2'h3;

  typedef enum logic [1:0] {
    DISP_MONITOR,
    DISP_LOCK_MSG,
    DISP_FREQ_EDIT
  } pkl_disp_t;

  // Step per dial click in 0.01 Hz units
  function automatic logic [15:0] step_of(input logic [2:0] sel);
    logic [15:0] s;
    s = STEP_DEFAULT;
    unique case (sel)
      3'h2: s = 16'h000A;
      3'h3: s = 16'h0064;
      3'h4: s = 16'h03E8;
      default: s = STEP_DEFAULT;
    endcase
    return s;
  endfunction : step_of

  function automatic logic lock_capable(input logic [7:0] sel);
    return (sel == LOCK_SEL_LOCK) || (sel == LOCK_SEL_LOCK_AUTO);
  endfunction : lock_capable

  function automatic logic auto_set(input logic [7:0] sel);
    return (sel == LOCK_SEL_AUTO) || (sel == LOCK_SEL_LOCK_AUTO);
  endfunction : auto_set

endpackage : pkl_pkg

// ==== verification/pkl_operator.sv ====
// Operator model: panel keys, dial clicks and mode key holds
`timescale 1ns/10ps
module pkl_operator (
  // Clock
  input wire logic i_clk_sys,
  // Keys: 0 set, 1 run, 2 stop, 3 mode switch, 4 dial up, 5 dial down
  output logic o_mode_key,
  output logic [5:0] o_keys
);
  initial begin
    o_mode_key = 1'b0;
    o_keys = 6'h00;
  end

  task automatic press(input int k);
    @(posedge i_clk_sys);
    o_keys[k] <= 1'b1;
    @(posedge i_clk_sys);
    o_keys[k] <= 1'b0;
    #1;
  endtask : press

  task automatic hold(input int n);
    @(posedge i_clk_sys);
    o_mode_key <= 1'b1;
    repeat (n) @(posedge i_clk_sys);
    o_mode_key <= 1'b0;
    #1;
  endtask : hold
endmodule : pkl_operator

// ==== verification/pkl_panel_bench.sv ====
// Bench for the panel key lock and dial step block
`timescale 1ns/10ps
module pkl_panel_bench;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk, rst_n, wr, rd, mode_key, edit_other, ps_event, op_init;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic [5:0] keys;
  logic [15:0] freq, dval, mon;
  logic run_f, run_r, stop_c, mode_a, p_up, p_dn, store, locked, warn, lmsg, fedit, spd;
  int bad_count = 0;
  int checks_done = 0;

  pkl_operator op (.i_clk_sys(clk), .o_mode_key(mode_key), .o_keys(keys));

  pkl_panel #(.HOLD_CYC(20), .MSG_CYC(20)) DUT (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wr_data(wdata), .i_wr(wr),
    .i_rd(rd), .o_rd_data(rdata), .i_mode_key(mode_key), .i_set_key(keys[0]),
    .i_run_key(keys[1]), .i_stop_key(keys[2]), .i_mode_switch_key(keys[3]),
    .i_dial_up(keys[4]), .i_dial_dn(keys[5]), .i_edit_other(edit_other),
    .i_op_mode_initial(op_init), .i_panel_stop_event(ps_event), .i_monitor_value(mon),
    .o_run_fwd(run_f), .o_run_rev(run_r), .o_stop_cmd(stop_c), .o_mode_action(mode_a),
    .o_param_up(p_up), .o_param_dn(p_dn), .o_freq_cmd(freq), .o_freq_store(store),
    .o_locked(locked), .o_panel_stop_warning(warn), .o_disp_lock_msg(lmsg),
    .o_disp_freq_edit(fedit), .o_disp_value(dval), .o_speed_units(spd));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic reg_test();
    logic [31:0] d;
    wr_reg(8'h00, 32'h0000_000A);
    rd_reg(8'h00, d);
    chk(d, 32'h0000_000A);
    wr_reg(8'h00, 32'h0000_0505);
    rd_reg(8'h00, d);
    chk(d, 32'h0000_000A);
    rd_reg(8'h0C, d);
    chk(d, 32'h0000_0000);
  endtask : reg_test

  task automatic lock_test();
    logic seen;
    wr_reg(8'h00, 32'h0000_0000);
    op.hold(25);
    cyc(2);
    chk(locked, 1'b0);
    wr_reg(8'h00, 32'h0000_000A);
    op.hold(3);
    seen = 1'b0;
    for (int i = 0; i < 5; i++) begin
      cyc(1);
      seen |= mode_a;
    end
    chk({seen, locked}, 2'b10);
    op.hold(25);
    cyc(2);
    chk({locked, lmsg}, 2'b11);
    op.press(2);
    chk(stop_c, 1'b1);
    chk(dval, 16'h1234);
    cyc(25);
    chk(lmsg, 1'b0);
    op.press(1);
    chk({run_f, run_r, lmsg}, 3'b001);
    cyc(15);
    chk(lmsg, 1'b1);
    cyc(10);
    chk(lmsg, 1'b0);
    op.hold(25);
    cyc(2);
    chk(locked, 1'b0);
  endtask : lock_test

  task automatic dial_test();
    logic [15:0] st [5];
    logic [15:0] e;
    logic [31:0] d;
    st = '{16'h0001, 16'h0001, 16'h000A, 16'h0064, 16'h03E8};
    e = 16'h0000;
    for (int s = 0; s < 5; s++) begin
      wr_reg(8'h00, 32'h0000_0001 | (32'(s) << 8) | (s == 4 ? 32'h2000 : 32'h0));
      op.press(4);
      e += st[s];
      chk({store, freq}, {1'b1, e});
    end
    chk(spd, 1'b1);
    op.press(5);
    e -= 16'h03E8;
    chk(freq, e);
    @(posedge clk);
    edit_other <= 1'b1;
    op.press(4);
    chk({p_up, freq}, {1'b1, e});
    op.press(5);
    chk({p_dn, freq}, {1'b1, e});
    @(posedge clk);
    edit_other <= 1'b0;
    wr_reg(8'h00, 32'h0000_0300);
    op.press(4);
    chk({fedit, freq}, {1'b1, e});
    op.press(0);
    chk({store, freq}, {1'b1, e + 16'h0064});
    rd_reg(8'h08, d);
    chk(d, {16'h0000, e + 16'h0064});
  endtask : dial_test

  task automatic run_test();
    for (int dir = 0; dir < 2; dir++) begin
      wr_reg(8'h00, dir == 1 ? 32'h0000_1000 : 32'h0000_0000);
      op.press(1);
      chk({run_f, run_r}, dir == 1 ? 2'b01 : 2'b10);
    end
  endtask : run_test

  task automatic warn_test();
    logic [31:0] d;
    wr_reg(8'h00, 32'h0000_000A);
    @(posedge clk);
    ps_event <= 1'b1;
    @(posedge clk);
    ps_event <= 1'b0;
    cyc(1);
    chk(warn, 1'b1);
    op.hold(25);
    repeat (3) op.press(3);
    chk({locked, warn}, 2'b11);
    rd_reg(8'h04, d);
    chk(d, 32'h0000_0007);
    op.hold(25);
    cyc(2);
    @(posedge clk);
    op_init <= 1'b0;
    repeat (3) op.press(3);
    chk(warn, 1'b1);
    @(posedge clk);
    op_init <= 1'b1;
    repeat (3) op.press(3);
    chk({locked, warn}, 2'b00);
  endtask : warn_test

  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    edit_other = 1'b0;
    ps_event = 1'b0;
    op_init = 1'b1;
    mon = 16'h1234;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    reg_test();
    lock_test();
    dial_test();
    run_test();
    warn_test();
    stop_test();
  end

  initial begin
    #300000;
    bad_count++;
    stop_test();
  end
endmodule : pkl_panel_bench
